// File: verilog/secp_pkg.sv
// package: constants and carriers for the serial memory command port
package secp_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int DEPTH = 64;
    localparam int INSTR_BITS = 9;
    localparam int DATA_BITS = 16;
    // instruction field positions within the 9-bit shift word
    localparam int START_POS = 8;
    localparam int OP_HI = 7;
    localparam int OP_LO = 6;
    localparam int ADDR_HI = 5;
    localparam int ADDR_LO = 0;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic PROG_EN_RESET = 1'b0;
    // self-timed programming cycle, longest figure
    localparam int PROG_TIME_US = 10000;
    localparam int CLK_MHZ = 50;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int TMR_W = 20;

    typedef enum logic [2:0] {
        SECP_NOP,
        SECP_WRITE,
        SECP_ERASE,
        SECP_ERASE_ALL,
        SECP_WRITE_ALL
    } secp_prog_t;

    typedef struct packed {
        logic sel;
        logic sclk;
        logic sdi;
    } secp_pins_t;

    typedef struct packed {
        logic start;
        secp_prog_t kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } secp_req_t;
endpackage

// File: verilog/secp_array.sv
// file: 64 x 16 storage array with whole-array erase and write
`timescale 1ns/100ps
module secp_array (
    input wire logic clk_sys,
    input wire logic [5:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic wr_en,
    input wire logic wr_all,
    input wire logic wr_and,
    input wire logic [5:0] wr_addr,
    input wire logic [15:0] wr_data
);
    // contents survive reset, like the floating gates
    logic [15:0] mem_q [secp_pkg::DEPTH];

    assign rd_data = mem_q[rd_addr];

    // a write only clears bits; an erase sets them
    function automatic logic [15:0] secp_next(input logic [15:0] old, input logic [15:0] nw,
            input logic and_mode);
        secp_next = and_mode ? (old & nw) : nw;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < secp_pkg::DEPTH; gi++) begin : g_word
            always_ff @(posedge clk_sys) begin
                if (wr_en && (wr_all || wr_addr == 6'(gi))) begin
                    mem_q[gi] <= secp_next(mem_q[gi], wr_data, wr_and);
                end
            end
        end
    endgenerate
endmodule

// File: verilog/secp_prog_timer.sv
// file: self-timed programming cycle counter
`timescale 1ns/100ps
module secp_prog_timer #(
    parameter int CYCLES = secp_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [secp_pkg::TMR_W-1:0] cnt;
        logic busy;
        logic done;
    } secp_tmr_t;

    secp_tmr_t s_q;
    secp_tmr_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt = secp_pkg::TMR_W'(CYCLES - 1);
        end else if (s_q.busy) begin
            if (s_q.cnt == '0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// File: verilog/secp_top.sv
// file: serial command port of a 64 x 16 nonvolatile memory
`timescale 1ns/100ps
module secp_top #(
    parameter int PROG_CYCLES = secp_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic select_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe
);
    typedef enum logic [2:0] {
        SECP_IDLE,
        SECP_INSTR,
        SECP_DATA,
        SECP_READ,
        SECP_ARMED,
        SECP_DONE
    } secp_state_t;

    typedef struct packed {
        secp_state_t st;
        secp_pkg::secp_pins_t pins;
        logic [secp_pkg::INSTR_BITS-1:0] sh;
        logic [4:0] cnt;
        logic [secp_pkg::DATA_W-1:0] dsh;
        logic [secp_pkg::DATA_W:0] osh;
        logic prog_en;
        secp_pkg::secp_req_t req;
        logic status;
        logic dout;
        logic doe;
    } secp_regs_t;

    secp_regs_t s_q;
    secp_regs_t s_d;
    logic [15:0] rd_data;
    logic tmr_busy;
    logic tmr_done;
    logic sk_rise;
    logic sel_fall;
    logic sel_rise;
    logic [1:0] op;
    logic [1:0] ext;
    logic wr_en;
    logic wr_all;
    logic wr_and;
    logic [15:0] wr_word;
    logic [5:0] word_addr;
    logic prog_active;
    logic instr_full;
    logic data_full;

    // edge seen between the previous sample and the present level of a pin
    function automatic logic secp_rise(input logic now, input logic prev);
        return now && !prev;
    endfunction

    // pins are synchronous to clk_sys; only the previous sample is kept,
    // so a serial clock level shorter than one clk_sys period may be missed
    assign sk_rise = secp_rise(serial_clock_pin, s_q.pins.sclk);
    assign sel_fall = secp_rise(!select_pin, !s_q.pins.sel);
    assign sel_rise = secp_rise(select_pin, s_q.pins.sel);
    // busy from the launch pulse to the end of the timed cycle
    assign prog_active = tmr_busy || s_q.req.start;
    assign instr_full = s_q.cnt == 5'(secp_pkg::INSTR_BITS);
    assign data_full = s_q.cnt == 5'(secp_pkg::DATA_BITS);
    assign word_addr = s_q.sh[secp_pkg::ADDR_HI:secp_pkg::ADDR_LO];
    assign op = s_q.sh[secp_pkg::OP_HI:secp_pkg::OP_LO];
    assign ext = s_q.sh[secp_pkg::ADDR_HI:secp_pkg::ADDR_HI-1];

    // erase-all and write-all touch every word in the same cycle
    function automatic logic secp_is_all(input secp_pkg::secp_prog_t kind);
        return kind inside {secp_pkg::SECP_ERASE_ALL, secp_pkg::SECP_WRITE_ALL};
    endfunction

    // writes merge with the old word, since programming only clears bits
    function automatic logic secp_is_write(input secp_pkg::secp_prog_t kind);
        return kind inside {secp_pkg::SECP_WRITE, secp_pkg::SECP_WRITE_ALL};
    endfunction

    // data out: status wins over read data; released otherwise
    function automatic logic [1:0] secp_drive(input logic show_status, input logic reading,
            input logic ready, input logic rd_bit);
        logic [1:0] r;
        r = 2'b00;
        if (show_status) begin
            r = {1'b1, ready};
        end else if (reading) begin
            r = {1'b1, rd_bit};
        end
        return r;
    endfunction

    // the array is changed when the timed cycle ends, which is when status turns ready
    always_comb begin
        wr_en = tmr_done;
        wr_all = secp_is_all(s_q.req.kind);
        wr_and = secp_is_write(s_q.req.kind);
        wr_word = wr_and ? s_q.req.data : secp_pkg::ERASED_WORD;
    end

    secp_array u_array (
        .clk_sys(clk_sys),
        .rd_addr(word_addr),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_all(wr_all),
        .wr_and(wr_and),
        .wr_addr(s_q.req.addr),
        .wr_data(wr_word)
    );

    secp_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(s_q.req.start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always_comb begin
        s_d = s_q;
        s_d.pins.sel = select_pin;
        s_d.pins.sclk = serial_clock_pin;
        s_d.pins.sdi = serial_in_pin;
        s_d.req.start = 1'b0;
        unique case (s_q.st)
            SECP_IDLE: begin
                if (select_pin && sk_rise && serial_in_pin) begin
                    s_d.st = SECP_INSTR;
                    s_d.sh = secp_pkg::INSTR_BITS'(1);
                    s_d.cnt = 5'h01;
                end
            end
            SECP_INSTR: begin
                if (select_pin && sk_rise) begin
                    s_d.sh = {s_q.sh[secp_pkg::INSTR_BITS-2:0], serial_in_pin};
                    s_d.cnt = s_q.cnt + 5'h01;
                end else if (instr_full) begin
                    s_d.cnt = 5'h00;
                    unique case (op)
                        secp_pkg::OP_READ: begin
                            // array read needs no enable
                            s_d.osh = {1'b0, rd_data};
                            s_d.st = SECP_READ;
                        end
                        secp_pkg::OP_WRITE: begin
                            s_d.req.kind = secp_pkg::SECP_WRITE;
                            s_d.st = SECP_DATA;
                        end
                        secp_pkg::OP_ERASE: begin
                            s_d.req.kind = secp_pkg::SECP_ERASE;
                            s_d.st = SECP_ARMED;
                        end
                        secp_pkg::OP_EXT: begin
                            unique case (ext)
                                secp_pkg::EXT_ENABLE: begin
                                    s_d.prog_en = 1'b1;
                                    s_d.st = SECP_DONE;
                                end
                                secp_pkg::EXT_DISABLE: begin
                                    s_d.prog_en = 1'b0;
                                    s_d.st = SECP_DONE;
                                end
                                secp_pkg::EXT_ERASE_ALL: begin
                                    s_d.req.kind = secp_pkg::SECP_ERASE_ALL;
                                    s_d.st = SECP_ARMED;
                                end
                                secp_pkg::EXT_WRITE_ALL: begin
                                    s_d.req.kind = secp_pkg::SECP_WRITE_ALL;
                                    s_d.st = SECP_DATA;
                                end
                            endcase
                        end
                    endcase
                    s_d.req.addr = word_addr;
                end
                if (sel_fall) begin
                    s_d.st = SECP_IDLE;
                end
            end
            SECP_DATA: begin
                // a short data word is dropped at select fall, never programmed
                if (select_pin && sk_rise && !data_full) begin
                    s_d.dsh = {s_q.dsh[secp_pkg::DATA_W-2:0], serial_in_pin};
                    s_d.cnt = s_q.cnt + 5'h01;
                end
                if (data_full) begin
                    s_d.req.data = s_q.dsh;
                    s_d.st = SECP_ARMED;
                end
                if (sel_fall) begin
                    s_d.st = SECP_IDLE;
                end
            end
            SECP_READ: begin
                // dummy zero already on the pin; shift on each rising clock
                if (select_pin && sk_rise) begin
                    s_d.osh = {s_q.osh[secp_pkg::DATA_W-1:0], 1'b0};
                end
                if (sel_fall) begin
                    s_d.st = SECP_IDLE;
                end
            end
            SECP_ARMED: begin
                // extra clocks past the last bit are ignored; falling select launches when prog_en is set
                if (sel_fall) begin
                    s_d.st = SECP_IDLE;
                    if (s_q.prog_en && !tmr_busy) begin
                        s_d.req.start = 1'b1;
                        s_d.status = 1'b1;
                    end
                end
            end
            SECP_DONE: begin
                if (sel_fall) begin
                    s_d.st = SECP_IDLE;
                end
            end
            // two state codes are unused; recover to idle from them
            default: begin
                s_d.st = SECP_IDLE;
            end
        endcase
        // no new instruction is taken while the array is busy
        if (prog_active && s_q.st == SECP_IDLE) begin
            s_d.st = SECP_IDLE;
        end
        if (sel_rise && !prog_active && !s_q.status) begin
            s_d.status = 1'b0;
        end
        // the fall that launches a cycle must not clear the status it sets
        if (sel_fall && !prog_active && !s_d.req.start) begin
            s_d.status = 1'b0;
        end
        // output enable and level
        {s_d.doe, s_d.dout} = secp_drive(s_q.status && select_pin,
            s_q.st == SECP_READ && select_pin, !prog_active,
            s_q.osh[secp_pkg::DATA_W]);
        if (s_d.st == SECP_IDLE && s_q.st != SECP_IDLE) begin
            s_d.cnt = 5'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.st <= SECP_IDLE;
            s_q.prog_en <= secp_pkg::PROG_EN_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // the serial clock may stop during programming; timer runs on clk_sys
    assign serial_out_pin = s_q.dout;
    assign serial_out_oe = s_q.doe;
endmodule

// File: testbench/secp_top_props.sv
// checker: pin-level timing relations of the command port
`timescale 1ns/100ps
module secp_top_props #(
    parameter int PROG_CYCLES = 200
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic select_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe
);
    localparam int WAIT_MAX = PROG_CYCLES + 8;
    logic sck_q, sel_q, done_q, en_q, armed_q, take;
    logic [4:0] cnt_q;
    logic [7:0] sh_q;
    logic [8:0] ins_q;
    // shadow decoder, so that a started program cycle is known here
    assign take = select_pin && serial_clock_pin && !sck_q && (cnt_q != 5'h00 || serial_in_pin);
    always_ff @(posedge clk_sys) begin
        sck_q <= serial_clock_pin;
        sel_q <= select_pin;
        done_q <= resetn && take && cnt_q == 5'h08;
        if (!resetn || !select_pin) begin
            cnt_q <= 5'h00;
            sh_q <= 8'h00;
        end else if (take && cnt_q != 5'h1F) begin
            cnt_q <= cnt_q + 5'h01;
            sh_q <= {sh_q[6:0], serial_in_pin};
        end
        if (!resetn) begin
            ins_q <= 9'h000;
            en_q <= 1'b0;
        end else if (take && cnt_q == 5'h08) begin
            ins_q <= {sh_q, serial_in_pin};
            if (sh_q[6:3] == 4'h3) en_q <= 1'b1;
            if (sh_q[6:3] == 4'h0) en_q <= 1'b0;
        end
        if (!resetn || (select_pin && !sel_q)) begin
            armed_q <= 1'b0;
        end else if (!select_pin && sel_q) begin
            armed_q <= en_q && ((cnt_q == 5'h09 && (ins_q[7:6] == 2'h3 || ins_q[7:4] == 4'h2))
                || (cnt_q == 5'h19 && (ins_q[7:6] == 2'h1 || ins_q[7:4] == 4'h1)));
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !serial_out_oe && !serial_out_pin)
        else $error("outputs driven after reset");
    a_sel_low_quiet: assert property (!select_pin [*4] |-> !serial_out_oe)
        else $error("output driven with select low");
    a_oe_release: assert property ($fell(select_pin) |-> ##[1:3] !serial_out_oe)
        else $error("output not released after select fall");
    a_launch_on_rise: assert property ($changed(serial_out_pin) && serial_out_oe && $past(serial_out_oe) && serial_clock_pin |-> !$past(serial_clock_pin, 4))
        else $error("read bit changed without a clock rise");
    a_read_dummy: assert property (done_q && ins_q[7:6] == 2'h2 |-> ##[1:3] (serial_out_oe && !serial_out_pin))
        else $error("no zero dummy bit after read");
    a_ext_no_drive: assert property (done_q && ins_q[7:6] == 2'h0 |-> !serial_out_oe [*4])
        else $error("output driven after extended command");
    a_no_status_idle: assert property ($rose(select_pin) && !armed_q |-> !serial_out_oe [*4])
        else $error("status shown with no cycle started");
    a_busy_then_ready: assert property ($rose(select_pin) && armed_q |-> ##[1:3] (serial_out_oe && !serial_out_pin) ##[1:WAIT_MAX] (serial_out_oe && serial_out_pin))
        else $error("busy then ready status not seen");
endmodule
bind secp_top secp_top_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk_sys(clk_sys),
    .resetn(resetn), .select_pin(select_pin), .serial_clock_pin(serial_clock_pin),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));

// File: testbench/secp_host_model.sv
// host model: drives select, serial clock and data in
`timescale 1ns/100ps
module secp_host_model (
    input wire logic clk_sys,
    output logic select_pin,
    output logic serial_clock_pin,
    output logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe
);
    initial begin
        select_pin = 1'b0;
        serial_clock_pin = 1'b0;
        serial_in_pin = 1'b0;
    end
    // outside frames data in never holds a value the port could latch
    always @(posedge clk_sys) begin
        if (!select_pin) serial_in_pin <= ~serial_in_pin;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // read data is sampled at the end of the high phase
    task automatic bit_out(input logic b, output logic seen);
        serial_in_pin <= b;
        serial_clock_pin <= 1'b0;
        tick(4);
        serial_clock_pin <= 1'b1;
        tick(4);
        seen = serial_out_pin;
    endtask
    task automatic frame_start();
        select_pin <= 1'b1;
        tick(1);
    endtask
    // select drops in the same step as the clock falls after the last bit
    task automatic frame_end();
        select_pin <= 1'b0;
        serial_clock_pin <= 1'b0;
        tick(60);
    endtask
    task automatic send_instr(input logic [1:0] op, input logic [5:0] a, output logic seen);
        logic [8:0] w;
        w = {1'b1, op, a};
        for (int i = 8; i >= 0; i--) bit_out(w[i], seen);
    endtask
    task automatic shift_word(input logic [15:0] d, output logic [15:0] q);
        logic s;
        for (int i = 15; i >= 0; i--) begin
            bit_out(d[i], s);
            q[i] = s;
        end
    endtask
    // serial clock stays still during the status check
    task automatic poll_status(output logic oe, output logic st);
        select_pin <= 1'b1;
        tick(4);
        oe = serial_out_oe;
        st = serial_out_pin;
    endtask
endmodule

// File: testbench/secp_tb_top.sv
// testbench: host-driven scenarios for the serial memory command port
`timescale 1ns/100ps
module serial_eeprom_command_port_tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic select_pin, serial_clock_pin, serial_in_pin, serial_out_pin, serial_out_oe;
    int err_total = 0;
    int num_checks = 0;
    always #10 clk_sys = ~clk_sys;
    secp_top #(.PROG_CYCLES(200)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
        .select_pin(select_pin), .serial_clock_pin(serial_clock_pin),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe));
    secp_host_model u_host (.clk_sys(clk_sys), .select_pin(select_pin),
        .serial_clock_pin(serial_clock_pin), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
        input logic wr);
        logic s;
        logic [15:0] q;
        u_host.frame_start();
        u_host.send_instr(op, a, s);
        if (wr) u_host.shift_word(d, q);
        u_host.frame_end();
    endtask
    task automatic status(input logic started);
        logic oe, st;
        int n;
        u_host.poll_status(oe, st);
        if (started) begin
            check("busy status", 16'h0000, {15'h0000, st});
            n = 0;
            while (st !== 1'b1 && n < 400) begin
                u_host.poll_status(oe, st);
                n++;
            end
            check("ready status", 16'h0001, {15'h0000, st});
        end
        check("status drive", {15'h0000, started}, {15'h0000, oe});
        u_host.frame_end();
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp, input int lead);
        logic s;
        logic [15:0] q;
        u_host.frame_start();
        repeat (lead) u_host.bit_out(1'b0, s);
        u_host.send_instr(secp_pkg::OP_READ, a, s);
        check("dummy bit", 16'h0000, {15'h0000, s});
        check("dummy drive", 16'h0001, {15'h0000, serial_out_oe});
        u_host.shift_word(16'h0000, q);
        check("read word", exp, q);
        u_host.frame_end();
    endtask
    task automatic t_power_up();
        cmd(secp_pkg::OP_ERASE, 6'h05, 16'h0000, 1'b0);
        status(1'b0);
        cmd(secp_pkg::OP_EXT, {secp_pkg::EXT_WRITE_ALL, 4'hA}, 16'h0000, 1'b1);
        status(1'b0);
        $display("test power_up done");
    endtask
    task automatic t_erase_all();
        cmd(secp_pkg::OP_EXT, {secp_pkg::EXT_ENABLE, 4'h5}, 16'h0000, 1'b0);
        cmd(secp_pkg::OP_EXT, {secp_pkg::EXT_ERASE_ALL, 4'hC}, 16'h0000, 1'b0);
        status(1'b1);
        rd(6'h00, 16'hFFFF, 0);
        rd(6'h3F, 16'hFFFF, 0);
        $display("test erase_all done");
    endtask
    task automatic t_write_read();
        cmd(secp_pkg::OP_WRITE, 6'h09, 16'hA5C3, 1'b1);
        status(1'b1);
        rd(6'h09, 16'hA5C3, 0);
        rd(6'h0A, 16'hFFFF, 0);
        cmd(secp_pkg::OP_ERASE, 6'h09, 16'h0000, 1'b0);
        status(1'b1);
        rd(6'h09, 16'hFFFF, 0);
        $display("test write_read done");
    endtask
    task automatic t_write_all();
        cmd(secp_pkg::OP_EXT, {secp_pkg::EXT_ERASE_ALL, 4'h1}, 16'h0000, 1'b0);
        status(1'b1);
        cmd(secp_pkg::OP_EXT, {secp_pkg::EXT_WRITE_ALL, 4'h3}, 16'h3C5A, 1'b1);
        status(1'b1);
        rd(6'h11, 16'h3C5A, 0);
        rd(6'h3F, 16'h3C5A, 0);
        $display("test write_all done");
    endtask
    task automatic t_framing();
        logic s;
        logic [4:0] p;
        p = 5'h1C;
        u_host.frame_start();
        for (int i = 4; i >= 0; i--) u_host.bit_out(p[i], s);
        u_host.frame_end();
        status(1'b0);
        rd(6'h11, 16'h3C5A, 3);
        $display("test framing done");
    endtask
    task automatic t_disabled();
        cmd(secp_pkg::OP_EXT, {secp_pkg::EXT_DISABLE, 4'hF}, 16'h0000, 1'b0);
        cmd(secp_pkg::OP_ERASE, 6'h11, 16'h0000, 1'b0);
        status(1'b0);
        cmd(secp_pkg::OP_WRITE, 6'h11, 16'h0000, 1'b1);
        status(1'b0);
        rd(6'h11, 16'h3C5A, 0);
        $display("test disabled done");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_power_up();
        t_erase_all();
        t_write_read();
        t_write_all();
        t_framing();
        t_disabled();
        complete_run();
    end
    // about six thousand cycles are expected; this allows plenty of slack
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        $display("unexpected run length: expected end seen hang");
        complete_run();
    end
endmodule
